// [design/cpmc_top.sv]
/*
 * clock source, divider, wait/stop mode and protect control.
 * assumes control bits come from the cpu core as synchronous levels
 * and pulses; nmi_n_in is the active-low nmi pin, synchronous.
 */
`timescale 1ns/1ns
module cpmc_top #(parameter int DIV_W = cpmc_pkg::DIV_W)
(
   input wire logic clk_in, // system clock, 10 mhz
   input wire logic reset_in, // async reset, active high
   input wire cpmc_pkg::cpmc_clk_cfg_t cfg_in, // clock config bits
   input wire logic cfg_we_in, // load cfg_in
   input wire logic idle_req_in, // wait instruction pulse
   input wire logic halt_req_in, // all_clocks_halt_bit set pulse
   input wire logic wake_in, // wake-up interrupt pulse
   input wire logic nmi_n_in, // nmi pin, active low
   input wire logic first_instr_done_in, // first instruction retired
   input wire logic protect_set_in, // third_protect_enable_bit set
   input wire logic any_write_in, // any write cycle
   input wire logic isp_we_in, // load stack pointer
   input wire logic [23:0] isp_in, // stack pointer value
   input wire logic [5:0] irq_pin_in, // external_irq_inputs
   input wire cpmc_pkg::cpmc_irq_ctl_t irq_ctl_in, // polarity, clears
   input wire logic other_irq_in, // other request this cycle
   output cpmc_pkg::cpmc_clk_cfg_t cfg_out, // current clock config
   output logic cpu_clk_en_out, // divided cpu clock enable
   output logic periph_clk_en_out, // peripheral clock enable
   output logic [3:0] mode_out, // one-hot run/idle/halt/wake
   output logic protect_out, // third_protect_enable_bit
   output logic [23:0] isp_out, // interrupt_stack_pointer
   output logic nmi_ack_out, // nmi accepted pulse
   output logic halt_refused_out, // stop refused pulse
   output logic [5:0] irq_req_out // request_pending_flag per pin
);
   // ********************************************
   // state
   // ********************************************
   typedef struct packed {
      cpmc_pkg::cpmc_clk_cfg_t cfg;
      cpmc_pkg::cpmc_mode_t mode;
      logic [DIV_W-1:0] cnt;
      logic cpu_en;
      logic per_en;
      logic protect;
      logic [23:0] interrupt_stack_pointer;
      logic nmi_ok;
      logic nmi_prev;
      logic nmi_ack;
      logic refused;
   } cpmc_state_t;
   cpmc_state_t s_q;
   cpmc_state_t s_d;
   logic [5:0] irq_req;

   initial
   begin
      // the counter compares against the five-bit divide field
      if (DIV_W < 1 || DIV_W > 5)
         $error("divider width out of range");
   end

   cpmc_irq_edge #(.N(cpmc_pkg::NIRQ)) u_irq (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .pin_in(irq_pin_in),
      .pol_in(irq_ctl_in.polarity),
      .clr_in(irq_ctl_in.clear_req),
      .req_out(irq_req)
   );

   // ********************************************
   // next state
   // ********************************************
   always_comb
   begin
      logic nmi_edge;
      logic running;
      nmi_edge = 1'b0;
      running = 1'b0;
      s_d = s_q;
      s_d.nmi_ack = 1'b0;
      s_d.refused = 1'b0;
      s_d.cpu_en = 1'b0;
      s_d.per_en = 1'b0;
      nmi_edge = s_q.nmi_prev && !nmi_n_in;
      s_d.nmi_prev = nmi_n_in;

      // config loads; caller keeps divider, osc and wait bits legal [RQ1] [RQ2]
      if (cfg_we_in)
         s_d.cfg = cfg_in;

      // nmi only after first instruction, never maskable [RQ14] [RQ15]
      if (first_instr_done_in)
         s_d.nmi_ok = 1'b1;
      // same-cycle requests may swallow the nmi ack [RQ16]
      if (nmi_edge && s_q.nmi_ok && !other_irq_in)
         s_d.nmi_ack = 1'b1;

      // stack pointer resets to zero, loaded by software [RQ13]
      if (isp_we_in)
         s_d.interrupt_stack_pointer = isp_in;

      // protect set wins over same-cycle write; later write clears [RQ11]
      if (protect_set_in)
         s_d.protect = 1'b1;
      else if (any_write_in)
         s_d.protect = 1'b0;

      case (s_q.mode)
         cpmc_pkg::CPMC_RUN:
         begin
            if (halt_req_in)
            begin
               // low nmi pin blocks stop entry [RQ7]
               if (!nmi_n_in)
                  s_d.refused = 1'b1;
               else
                  s_d.mode = cpmc_pkg::CPMC_HALT;
            end
            // core keeps fetching past the wait; software pads no-ops [RQ4]
            else if (idle_req_in)
               s_d.mode = cpmc_pkg::CPMC_IDLE;
         end
         cpmc_pkg::CPMC_IDLE:
            if (wake_in || nmi_edge)
               s_d.mode = cpmc_pkg::CPMC_RUN;
         cpmc_pkg::CPMC_HALT:
            if (wake_in || nmi_edge)
               s_d.mode = cpmc_pkg::CPMC_WAKE;
         // one slot for the queued instruction before the wake routine [RQ10]
         cpmc_pkg::CPMC_WAKE:
            s_d.mode = cpmc_pkg::CPMC_RUN;
         default:
            s_d.mode = cpmc_pkg::CPMC_RUN;
      endcase

      // divider: field 0 means undivided main clock
      running = (s_q.mode == cpmc_pkg::CPMC_RUN) || (s_q.mode == cpmc_pkg::CPMC_WAKE);
      if (s_q.cnt >= s_q.cfg.main_divide_field[DIV_W-1:0] || s_q.cfg.main_divide_field == '0)
      begin
         s_d.cnt = '0;
         s_d.cpu_en = running;
         // periph halt in idle; slow clock peripheral untouched here [RQ21] [RQ3]
         s_d.per_en = running || (s_q.mode == cpmc_pkg::CPMC_IDLE &&
                                  !s_q.cfg.periph_halt_in_idle_bit);
      end
      else
         s_d.cnt = s_q.cnt + 1'b1;
   end

   // ********************************************
   // registers
   // ********************************************
   always_ff @(posedge clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         s_q <= '0;
         s_q.cfg.main_divide_field <= cpmc_pkg::DIV_RESET;
         s_q.mode <= cpmc_pkg::CPMC_RUN;
         s_q.interrupt_stack_pointer <= cpmc_pkg::ISP_RESET;
         s_q.nmi_prev <= 1'b1;
      end
      else
         s_q <= s_d;
   end

   // outputs straight from flip-flops
   always_ff @(posedge clk_in or posedge reset_in)
   begin
      if (reset_in)
         irq_req_out <= '0;
      else
         irq_req_out <= irq_req;
   end

   assign cfg_out = s_q.cfg;
   assign cpu_clk_en_out = s_q.cpu_en;
   assign periph_clk_en_out = s_q.per_en;
   assign mode_out = s_q.mode;
   assign protect_out = s_q.protect;
   assign isp_out = s_q.interrupt_stack_pointer;
   assign nmi_ack_out = s_q.nmi_ack;
   assign halt_refused_out = s_q.refused;
endmodule : cpmc_top

// [design/cpmc_pkg.sv]
/*
 * constants and carrier types for the clock and power mode controller.
 * assumes one 10 mhz system clock and synchronous control inputs.
 */
// Behaviour
// RQ1 - never halt main osc while external clock
// RQ2 - clear bus wait before changing divider
// RQ3 - divide to 10 MHz before peripheral-halting wait
// RQ4 - prefetch runs past halt; four no-ops follow
// RQ5 - deselect sub, pll, slow before stop
// RQ6 - pll source: select main, pll off first
// RQ7 - stop refused while nmi input low
// RQ8 - hold reset low until oscillator stable
// RQ9 - dummy interrupt before stopping clocks again
// RQ10 - queued instruction runs before wake routine
// RQ11 - third protect bit clears on next write
// RQ12 - no interrupt or dma after protect set
// RQ13 - stack pointer resets to zero, load first
// RQ14 - nmi accepted only after first instruction
// RQ15 - nmi cannot be masked
// RQ16 - simultaneous nmi may go unacknowledged
// RQ17 - polarity change may set request flag
// RQ18 - refresh watchdog after its interrupt
// RQ19 - clear request flag with plain move
// RQ20 - other fields only by and/or/bit ops
// RQ21 - slow clock peripheral runs through wait
// RQ22 - grouped request bits cleared by and only
package cpmc_pkg;
   // ********************************************
   // widths, reset values, clock rates and no-op count
   // ********************************************
   localparam int DIV_W = 5;
   localparam int ISP_W = 24;
   localparam int NIRQ = 6;
   localparam logic [4:0] DIV_RESET = 5'h08;
   localparam logic [23:0] ISP_RESET = 24'h000000;
   localparam int CLK_HZ = 10000000;
   localparam int CPU_MAX_IDLE_HZ = 10000000;
   localparam int PREFETCH_NOPS = 4;

   // ********************************************
   // types
   // ********************************************
   typedef enum logic [3:0] {
      CPMC_RUN = 4'h1,
      CPMC_IDLE = 4'h2,
      CPMC_HALT = 4'h4,
      CPMC_WAKE = 4'h8
   } cpmc_mode_t;

   typedef struct packed {
      logic main_osc_halt_bit;
      logic bus_wait_insert_bit;
      logic periph_halt_in_idle_bit;
      logic main_or_pll_select_bit;
      logic pll_or_divided_select_bit;
      logic slow_clock_select_bit;
      logic pll_power_bit;
      logic [4:0] main_divide_field;
   } cpmc_clk_cfg_t;

   typedef struct packed {
      logic [5:0] polarity;
      logic [5:0] clear_req;
   } cpmc_irq_ctl_t;
endpackage : cpmc_pkg

// [design/cpmc_irq_edge.sv]
/*
 * external interrupt request flags with selectable polarity.
 * assumes pins already synchronous to clk_in.
 */
`timescale 1ns/1ns
module cpmc_irq_edge #(parameter int N = cpmc_pkg::NIRQ)
(
   input wire logic clk_in, // system clock
   input wire logic reset_in, // async reset
   input wire logic [N-1:0] pin_in, // external irq pins
   input wire logic [N-1:0] pol_in, // 1 = rising edge
   input wire logic [N-1:0] clr_in, // clear pulse per flag
   output logic [N-1:0] req_out // request pending flags
);
   typedef struct packed {
      logic [N-1:0] lvl;
      logic [N-1:0] pol;
      logic [N-1:0] req;
   } cpmc_edge_st_t;
   cpmc_edge_st_t s_q;
   cpmc_edge_st_t s_d;

   // effective level folds polarity, so a polarity flip looks like an edge
   always_comb
   begin
      s_d = s_q;
      s_d.lvl = pin_in ~^ pol_in;
      s_d.pol = pol_in;
      for (int i = 0; i < N; i++)
      begin
         // set beats clear; polarity switch may set flag [RQ17]
         // a plain clear pulse loses to a same-cycle edge, never drops it [RQ19] [RQ20]
         if (s_d.lvl[i] && !s_q.lvl[i])
            s_d.req[i] = 1'b1;
         else if (clr_in[i])
            s_d.req[i] = 1'b0;
      end
   end

   always_ff @(posedge clk_in or posedge reset_in)
   begin
      // level resets high, the asserted state of a low-active pin, so no edge is seen in the first cycle
      if (reset_in)
         s_q <= '{lvl: '1, pol: '0, req: '0};
      else
         s_q <= s_d;
   end

   assign req_out = s_q.req;
endmodule : cpmc_irq_edge

// [dv/cpmc_chk.sv]
/* port checker for the clock and power mode controller.
   assumes a bind to cpmc_top, one clock, reset active high. */
`timescale 1ns/1ns
module cpmc_chk
(
   input wire logic clk_in, // clock
   input wire logic reset_in, // reset
   input wire logic halt_req_in, // stop request
   input wire logic wake_in, // wake pulse
   input wire logic nmi_n_in, // nmi pin
   input wire logic first_instr_done_in, // first instr
   input wire logic protect_set_in, // protect set
   input wire logic any_write_in, // write cycle
   input wire logic isp_we_in, // isp load
   input wire logic [23:0] isp_in, // isp value
   input wire logic other_irq_in, // other request
   input wire logic [3:0] mode_out, // mode
   input wire logic protect_out, // protect
   input wire logic [23:0] isp_out, // isp
   input wire logic nmi_ack_out, // nmi accepted
   input wire logic halt_refused_out // stop refused
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);
   logic seen_q;
   // sticky first instruction, so acks before it can be caught
   always_ff @(posedge clk_in or posedge reset_in)
      if (reset_in) seen_q <= 1'b0;
      else if (first_instr_done_in) seen_q <= 1'b1;
   sequence s_wake;
      mode_out == 4'h8 ##1 mode_out == 4'h1;
   endsequence
   property p_refuse;
      halt_req_in && !nmi_n_in && mode_out == 4'h1 |=> halt_refused_out && mode_out == 4'h1;
   endproperty
   property p_halt;
      halt_req_in && nmi_n_in && mode_out == 4'h1 |=> mode_out == 4'h4 && !halt_refused_out;
   endproperty
   property p_wake;
      wake_in && mode_out == 4'h4 |=> s_wake;
   endproperty
   property p_prot_set;
      protect_set_in |=> protect_out;
   endproperty
   property p_prot_clr;
      protect_out && any_write_in && !protect_set_in |=> !protect_out;
   endproperty
   property p_isp_load;
      isp_we_in |=> isp_out == $past(isp_in);
   endproperty
   property p_nmi_first;
      nmi_ack_out |-> seen_q;
   endproperty
   property p_nmi_take;
      $fell(nmi_n_in) && seen_q && !other_irq_in |=> nmi_ack_out;
   endproperty
   property p_nmi_other;
      other_irq_in |=> !nmi_ack_out;
   endproperty
   a_refuse: assert property (p_refuse) else $error("stop not refused");
   a_halt: assert property (p_halt) else $error("stop not entered");
   a_wake: assert property (p_wake) else $error("wake order wrong");
   a_prot_set: assert property (p_prot_set) else $error("protect not set");
   a_prot_clr: assert property (p_prot_clr) else $error("protect not cleared");
   a_isp_load: assert property (p_isp_load) else $error("isp not loaded");
   a_nmi_first: assert property (p_nmi_first) else $error("nmi too early");
   a_nmi_take: assert property (p_nmi_take) else $error("nmi not taken");
   a_nmi_other: assert property (p_nmi_other) else $error("nmi ack clash");
endmodule : cpmc_chk

// [dv/cpmc_pins_model.sv]
/* far-side model of the nmi pin and its pull-up.
   assumes the bench says when the pin is pulled low. */
`timescale 1ns/1ns
module cpmc_pins_model
(
   input wire logic nmi_low_in, // pull pin low
   output logic nmi_n_out // nmi pin level
);
   // an unused pin rests high on its pull-up
   assign nmi_n_out = ~nmi_low_in;
endmodule : cpmc_pins_model

// [dv/test_clock_power_mode_control.sv]
/* self-checking bench for cpmc_top.
   assumes the pin model and checker files are compiled first. */
`timescale 1ns/1ns
module test_clock_power_mode_control;
   logic clk_in, reset_in, halt, wake, nlow, first, pset, wr, iwe, oth;
   logic cwe, idl, cen, pen;
   cpmc_pkg::cpmc_clk_cfg_t cfgi;
   logic [23:0] interrupt_stack_pointer;
   logic [5:0] pins;
   cpmc_pkg::cpmc_irq_ctl_t ictl;
   cpmc_pkg::cpmc_clk_cfg_t cfg;
   logic [3:0] mode;
   logic prot, ack, refd, nmi_n;
   logic [23:0] ispo;
   logic [5:0] req;
   int mismatches = 0;
   int check_count = 0;
   // {nmi low, refused, mode after stop request}
   logic [5:0] rows [2] = '{6'h04, 6'h31};
   cpmc_pins_model i_pins (.nmi_low_in(nlow), .nmi_n_out(nmi_n));
   cpmc_top i_dut (.clk_in(clk_in), .reset_in(reset_in), .cfg_in(cfgi), .cfg_we_in(cwe),
      .idle_req_in(idl), .halt_req_in(halt), .wake_in(wake), .nmi_n_in(nmi_n),
      .first_instr_done_in(first), .protect_set_in(pset), .any_write_in(wr),
      .isp_we_in(iwe), .isp_in(interrupt_stack_pointer), .irq_pin_in(pins), .irq_ctl_in(ictl),
      .other_irq_in(oth), .cfg_out(cfg), .cpu_clk_en_out(cen), .periph_clk_en_out(pen),
      .mode_out(mode), .protect_out(prot), .isp_out(ispo), .nmi_ack_out(ack),
      .halt_refused_out(refd), .irq_req_out(req));
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      check_count++;
      if (got !== exp)
      begin
         mismatches++;
         $display("Error %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic tk(input int n);
      repeat (n) @(posedge clk_in);
   endtask : tk
   task automatic finish_test;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : finish_test
   // free-running 10 mhz clock
   initial
   begin
      clk_in = 1'b0;
      forever #50 clk_in = ~clk_in;
   end
   // a hang counts against the run
   initial
   begin
      #1000000;
      mismatches++;
      finish_test();
   end
   // ****************
   // main sequence
   // ****************
   initial
   begin
      {halt, wake, nlow, first, pset, wr, iwe, oth, interrupt_stack_pointer, pins, ictl} = '0;
      {cwe, idl, cfgi} = '0;
      reset_in = 1'b1; // long reset covers oscillator settling
      tk(20);
      reset_in <= 1'b0;
      tk(1);
      #1 chk(mode, 4'h1);
      chk(ispo, 24'h000000);
      chk({prot, req, cfg.main_divide_field}, 12'h008);
      $display("reset test done");
      // stop with nmi high then low; the first stop is entered and woken, the second refused
      for (int i = 0; i < 2; i++)
      begin
         tk(1);
         nlow <= rows[i][5];
         halt <= 1'b1;
         tk(1);
         halt <= 1'b0;
         #1 chk(mode, rows[i][3:0]);
         chk({refd, ack}, {rows[i][4], 1'b0});
         nlow <= 1'b0;
         wake <= 1'b1; // core runs a dummy interrupt before the next stop
         tk(1);
         wake <= 1'b0;
         tk(2);
         #1 chk(mode, 4'h1);
      end
      $display("stop test done");
      oth <= 1'b0; // no interrupt between protect set and its write
      pset <= 1'b1; // set and a write together: set wins
      wr <= 1'b1;
      iwe <= 1'b1;
      interrupt_stack_pointer <= 24'h00F00E;
      tk(1);
      {pset, iwe} <= 2'h0;
      #1 chk({prot, ispo}, {1'b1, 24'h00F00E});
      tk(1);
      wr <= 1'b0;
      #1 chk(prot, 1'b0);
      first <= 1'b1;
      tk(1);
      nlow <= 1'b1;
      oth <= 1'b1;
      tk(1);
      oth <= 1'b0;
      #1 chk(ack, 1'b0);
      nlow <= 1'b0;
      tk(1);
      nlow <= 1'b1;
      tk(1);
      #1 chk(ack, 1'b1);
      tk(1);
      #1 chk(ack, 1'b0);
      $display("protect and nmi tests done");
      ictl.polarity <= 6'h3F; // pins low: effective level falls, so the change sets no flag
      tk(3);
      ictl.clear_req <= 6'h3F; // plain clear pulse on all six request flags
      tk(1);
      ictl.clear_req <= 6'h00;
      tk(2);
      #1 chk(req, 6'h00);
      pins <= 6'h21;
      tk(3);
      #1 chk(req, 6'h21);
      $display("irq test done");
      // main clock undivided, wait off, selects cleared, peripherals halt in idle
      tk(1);
      cfgi <= 12'h200;
      cwe <= 1'b1;
      tk(1);
      cwe <= 1'b0;
      tk(1);
      #1 chk(cfg, 12'h200);
      chk({cen, pen}, 2'h3);
      idl <= 1'b1; // core pads four no-ops after the wait
      tk(1);
      idl <= 1'b0;
      #1 chk(mode, 4'h2);
      tk(1);
      #1 chk({cen, pen}, 2'h0);
      wake <= 1'b1;
      tk(1);
      wake <= 1'b0;
      #1 chk(mode, 4'h1);
      $display("idle test done");
      finish_test();
   end
endmodule : test_clock_power_mode_control
bind cpmc_top cpmc_chk i_chk (.clk_in, .reset_in, .halt_req_in, .wake_in, .nmi_n_in,
   .first_instr_done_in, .protect_set_in, .any_write_in, .isp_we_in, .isp_in, .other_irq_in,
   .mode_out, .protect_out, .isp_out, .nmi_ack_out, .halt_refused_out);
